//--- core/raf_defs.vh
// Purpose: Constants for the receive address filter block
// Assumes: Included by raf_rx_address_filter.v only
// Notes:   Byte addresses are printed offsets; data is one 32-bit word
`ifndef RAF_DEFS_VH
`define RAF_DEFS_VH

// Register map, byte addresses
`define RAF_MTA_BASE      16'h5200
`define RAF_MTA_WORDS     32
`define RAF_ST_LO         16'h5400
`define RAF_ST_HI         16'h5404
`define RAF_SH_LO_BASE    16'h5408
`define RAF_SH_HI_BASE    16'h540c
`define RAF_SH_STEP       16'h0008
`define RAF_SH_COUNT      11
`define RAF_CTRL          16'h5100
`define RAF_STAT          16'h5104

// High word field positions
`define RAF_HI_ADDR_MSB   15
`define RAF_SEL_LSB       16
`define RAF_SEL_MSB       17
`define RAF_IDX_BIT       18
`define RAF_AV_BIT        31

// Select encodings
`define RAF_SEL_DEST      2'b00
`define RAF_SEL_SRC       2'b01

// Multicast offset encodings
`define RAF_MO_47_38      2'b00
`define RAF_MO_46_37      2'b01
`define RAF_MO_45_36      2'b10
`define RAF_MO_43_34      2'b11

// Reset values
`define RAF_ZERO32        32'h0000_0000
`define RAF_CTRL_RST      2'b00

`endif

//--- core/raf_rx_address_filter.v
// Purpose: Receive destination/source address filter with host registers
// Assumes: All inputs synchronous to core_clk; one frame check per strobe
// Notes:   frame_da[7:0] is the first byte on the wire, bit 0 first
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "raf_defs.vh"

module raf_rx_address_filter (
  input  wire        core_clk,
  input  wire        reset,
  // Reset and non-volatile store load sources
  input  wire        sw_reset,
  input  wire        pci_reset,
  input  wire        nvm_load,
  input  wire        nvm_present,
  input  wire [15:0] nvm_word0,
  input  wire [15:0] nvm_word1,
  input  wire [15:0] nvm_word2,
  // Host register port
  input  wire [15:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Management engine port and lock field
  input  wire [10:0] firmware_write_lock,
  input  wire [15:0] me_addr,
  input  wire [31:0] me_wdata,
  input  wire        me_wr,
  // Receive frame path
  input  wire        frame_valid,
  input  wire [47:0] frame_da,
  input  wire [47:0] frame_sa,
  // Match results, one cycle after frame_valid
  output reg         match_valid,
  output reg         match_accept,
  output reg         exact_hit,
  output reg         mc_hit,
  output reg         pause_da_hit,
  output reg         pool_output_index,
  output reg  [3:0]  match_entry
);

  // Storage overview
  // Every register lives in plain flip-flops, so a read never waits
  // Table words and addresses come out of reset at zero, not unknown
  // Zero reset keeps match results clean before software has run
  // The cost is a reset fan-out to well over a thousand flip-flops
  // Primary entry keeps select and index beside its address
  // Shared entries never store a select field at all
  // Reserved high word bits have no storage behind them
  // So a write to them has nothing to land in
  // Multicast bit table
  reg [31:0] mta_q [0:31];
  // Primary entry fields
  reg [31:0] st_lo_q;
  reg [15:0] st_hi_q;
  reg [1:0]  st_sel_q;
  reg        st_idx_q;
  reg        st_av_q;
  // Shared entry fields
  reg [31:0] sh_lo_q  [0:10];
  reg [15:0] sh_hi_q  [0:10];
  reg        sh_idx_q [0:10];
  reg        sh_av_q  [0:10];
  // Own control: multicast offset
  reg [1:0]  mc_offset_q;
  // Load request pending after master reset
  reg        load_pend_q;

  // Combinational decode and match terms
  reg [31:0] rd_d;
  reg [9:0]  mc_idx;
  reg [31:0] mc_word;
  reg        mc_bit;
  reg        st_hit;
  reg        sh_any;
  reg        sh_idx;
  reg [3:0]  sh_num;
  reg [47:0] st_cmp;
  integer    k;                  // Loop index, read decode only
  integer    j;                  // Loop index, exact compare only

  // Address decode
  // Exact compares for the single registers keep aliases out
  // The table window ignores the low two address bits on reads
  // Writes need a word-aligned address, since only whole words exist
  // Software masks out the wanted bit after each table read
  // Host decode strobes for single registers
  wire host_st_lo = reg_wr && (reg_addr == `RAF_ST_LO);
  wire host_st_hi = reg_wr && (reg_addr == `RAF_ST_HI);
  wire host_ctrl  = reg_wr && (reg_addr == `RAF_CTRL);
  // Table window covers 32 consecutive words
  wire mta_wsel   = (reg_wr &&
                     reg_addr[15:7] == `RAF_MTA_BASE >> 7 &&
                     reg_addr[1:0] == 2'b00);
  wire mta_rsel   = (reg_addr[15:7] == `RAF_MTA_BASE >> 7);
  // Primary reload, master reset clears and then loads once
  wire reload     = sw_reset | pci_reset | nvm_load | load_pend_q;

  // Table write path
  // One word per write strobe; no byte lanes exist on this port
  // Word number comes straight from address bits 6:2
  // Reset clears every word, so no stale bit accepts a group frame
  // Limitation: a table change takes effect on the next frame strobe
  // Multicast table writes, whole words only
  always @(posedge core_clk) begin : mta_wr
    integer i;
    if (reset) begin
      for (i = 0; i < `RAF_MTA_WORDS; i = i + 1) begin
        mta_q[i] <= `RAF_ZERO32;
      end
    end else if (mta_wsel) begin
      mta_q[reg_addr[6:2]] <= reg_wdata;
    end
  end

  // Own control register
  always @(posedge core_clk) begin
    if (reset) begin
      mc_offset_q <= `RAF_CTRL_RST;
    end else if (host_ctrl) begin
      mc_offset_q <= reg_wdata[1:0];
    end
  end

  // Primary entry update
  // Master reset clears valid and arms one reload for the next cycle
  // Software reset, bus reset and store read all trigger a reload
  // Reload beats a host write in the same cycle, by design
  // Hazard: a host write in the first cycle after reset is lost
  // Without a store, a reload leaves the host value untouched
  // except after software or master reset, which clear valid
  // Index bit is never reloaded; it keeps what the host wrote
  // Primary entry: resets, store load and host writes
  always @(posedge core_clk) begin
    if (reset) begin
      st_lo_q     <= `RAF_ZERO32;
      st_hi_q     <= 16'h0000;
      st_sel_q    <= `RAF_SEL_DEST;
      st_idx_q    <= 1'b0;
      st_av_q     <= 1'b0;
      load_pend_q <= 1'b1;
    end else if (reload) begin
      load_pend_q <= 1'b0;
      if (nvm_present) begin
        // Store words 0,1 form the low word, word 2 the high half
        st_lo_q  <= {nvm_word1, nvm_word0};
        st_hi_q  <= nvm_word2;
        st_sel_q <= `RAF_SEL_DEST;
        st_av_q  <= 1'b1;
      end else if (sw_reset | load_pend_q) begin
        // No store: valid stays clear after reset
        st_av_q  <= 1'b0;
      end
    end else begin
      if (host_st_lo) begin
        st_lo_q <= reg_wdata;
      end
      if (host_st_hi) begin
        // Bits 30:19 are not stored, so they are dropped
        st_hi_q  <= reg_wdata[`RAF_HI_ADDR_MSB:0];
        st_sel_q <= reg_wdata[`RAF_SEL_MSB:`RAF_SEL_LSB];
        st_idx_q <= reg_wdata[`RAF_IDX_BIT];
        st_av_q  <= reg_wdata[`RAF_AV_BIT];
      end
    end
  end

  // Shared entry update
  // Each pair decodes its own low and high address
  // Lock bit i hands pair i to the management engine alone
  // Host writes to a locked pair are dropped without any error
  // Engine writes to an unlocked pair are dropped the same way
  // The two paths never meet on one pair, so no arbitration
  // Address compares unroll into eleven small decoders
  // Trade-off: simple decode over a shared address comparator
  // Shared entries: host writes unlocked pairs, engine locked ones
  always @(posedge core_clk) begin : sh_wr
    integer i;
    reg [15:0] lo_a;
    reg [15:0] hi_a;
    reg        h_ok;
    reg        m_ok;
    reg [31:0] wd;
    lo_a = 16'h0000;
    hi_a = 16'h0000;
    h_ok = 1'b0;
    m_ok = 1'b0;
    wd   = `RAF_ZERO32;
    for (i = 0; i < `RAF_SH_COUNT; i = i + 1) begin
      lo_a = `RAF_SH_LO_BASE + i[15:0] * `RAF_SH_STEP;
      hi_a = `RAF_SH_HI_BASE + i[15:0] * `RAF_SH_STEP;
      // Lock decides which path may write this pair
      h_ok = reg_wr && !firmware_write_lock[i];
      m_ok = me_wr && firmware_write_lock[i];
      wd   = m_ok ? me_wdata : reg_wdata;
      if (reset) begin
        sh_lo_q[i]  <= `RAF_ZERO32;
        sh_hi_q[i]  <= 16'h0000;
        sh_idx_q[i] <= 1'b0;
        sh_av_q[i]  <= 1'b0;
      end else begin
        if ((h_ok && reg_addr == lo_a) || (m_ok && me_addr == lo_a)) begin
          sh_lo_q[i] <= wd;
        end
        if ((h_ok && reg_addr == hi_a) || (m_ok && me_addr == hi_a)) begin
          // Select field is not stored; it reads as 00
          sh_hi_q[i]  <= wd[`RAF_HI_ADDR_MSB:0];
          sh_idx_q[i] <= wd[`RAF_IDX_BIT];
          sh_av_q[i]  <= wd[`RAF_AV_BIT];
        end
      end
    end
  end

  // Read multiplexer
  // Fully combinational, registered once below
  // Later matches in this chain override earlier ones
  // Shared decodes sit last, but their addresses never overlap
  // Reserved fields and the shared select field are built from constants here
  // Status word mirrors the lock field and store presence
  // Read decode; unmapped addresses read zero
  always @* begin
    rd_d = `RAF_ZERO32;
    if (mta_rsel) begin
      rd_d = mta_q[reg_addr[6:2]];
    end else if (reg_addr == `RAF_ST_LO) begin
      rd_d = st_lo_q;
    end else if (reg_addr == `RAF_ST_HI) begin
      // Reserved bits 30:19 forced to zero
      rd_d = {st_av_q, 12'h000, st_idx_q, st_sel_q, st_hi_q};
    end else if (reg_addr == `RAF_CTRL) begin
      rd_d = {30'h0000_0000, mc_offset_q};
    end else if (reg_addr == `RAF_STAT) begin
      rd_d = {15'h0000, nvm_present, 5'h00, firmware_write_lock};
    end
    for (k = 0; k < `RAF_SH_COUNT; k = k + 1) begin
      if (reg_addr == `RAF_SH_LO_BASE + k[15:0] * `RAF_SH_STEP) begin
        rd_d = sh_lo_q[k];
      end
      if (reg_addr == `RAF_SH_HI_BASE + k[15:0] * `RAF_SH_STEP) begin
        rd_d = {sh_av_q[k], 12'h000, sh_idx_q[k], 2'b00, sh_hi_q[k]};
      end
    end
  end

  // Read data stands in the cycle after the strobe
  always @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= `RAF_ZERO32;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end
  end

  // Multicast lookup
  // Destination is held with the first wire bit in bit 0
  // Offset setting slides a ten-bit window in the top bytes
  // Index picks one of 1024 table bits
  // Lookup is purely combinational on the live frame address
  // Group bit gating happens where results are registered
  // Multicast index selection from the destination address
  always @* begin
    case (mc_offset_q)
      `RAF_MO_47_38: mc_idx = frame_da[47:38];
      `RAF_MO_46_37: mc_idx = frame_da[46:37];
      `RAF_MO_45_36: mc_idx = frame_da[45:36];
      `RAF_MO_43_34: mc_idx = frame_da[43:34];
      default:       mc_idx = frame_da[47:38];
    endcase
    // Upper five bits pick the word, lower five the bit
    mc_word = mta_q[mc_idx[9:5]];
    mc_bit  = mc_word[mc_idx[4:0]];
  end

  // Exact-match compare
  // Primary may check source or destination, by its select field
  // Reserved select codes force a mismatch rather than a guess
  // Shared pairs always check the destination field
  // Loop runs downward so the lowest matching pair is kept
  // Twelve 48-bit comparators: wide, but one cycle of latency
  // Exact-match compare; lowest shared pair wins on multiple hits
  always @* begin
    // Select decides which address field the primary entry checks
    case (st_sel_q)
      `RAF_SEL_DEST: st_cmp = frame_da;
      `RAF_SEL_SRC:  st_cmp = frame_sa;
      default:       st_cmp = ~{st_hi_q, st_lo_q};
    endcase
    st_hit = st_av_q && (st_cmp == {st_hi_q, st_lo_q}) &&
             (st_sel_q == `RAF_SEL_DEST || st_sel_q == `RAF_SEL_SRC);
    sh_any = 1'b0;
    sh_idx = 1'b0;
    sh_num = 4'h0;
    for (j = `RAF_SH_COUNT - 1; j >= 0; j = j - 1) begin
      if (sh_av_q[j] && frame_da == {sh_hi_q[j], sh_lo_q[j]}) begin
        sh_any = 1'b1;
        sh_idx = sh_idx_q[j];
        sh_num = j[3:0] + 4'h1;
      end
    end
  end

  // Result registers
  // All results come straight from flip-flops
  // Valid pulses for one cycle; the rest hold until the next frame
  // Primary hit outranks any shared hit
  // Entry code 0 is primary, 1 to 11 shared, 15 means no hit
  // Pause check ignores select, it always looks at destination
  // Accept is the sum of exact and multicast hits
  // Registered match results, one cycle after the frame strobe
  always @(posedge core_clk) begin
    if (reset) begin
      match_valid       <= 1'b0;
      match_accept      <= 1'b0;
      exact_hit         <= 1'b0;
      mc_hit            <= 1'b0;
      pause_da_hit      <= 1'b0;
      pool_output_index <= 1'b0;
      match_entry       <= 4'hf;
    end else begin
      match_valid <= frame_valid;
      if (frame_valid) begin
        exact_hit <= st_hit | sh_any;
        // Group bit is the first bit on the wire
        mc_hit    <= frame_da[0] & mc_bit;
        match_accept <= st_hit | sh_any | (frame_da[0] & mc_bit);
        // Pause checking always uses the primary destination
        pause_da_hit <= st_av_q &&
                        frame_da == {st_hi_q, st_lo_q};
        if (st_hit) begin
          pool_output_index <= st_idx_q;
          match_entry       <= 4'h0;
        end else if (sh_any) begin
          pool_output_index <= sh_idx;
          match_entry       <= sh_num;
        end else begin
          pool_output_index <= 1'b0;
          match_entry       <= 4'hf;
        end
      end
    end
  end

endmodule // raf_rx_address_filter

//--- testbench/raf_checker.sv
// Purpose: Port assertions for the receive address filter
// Assumes: Bound to raf_rx_address_filter, one clock domain
// Notes:   Watches design ports only, inputs and outputs alike
`timescale 1ns/1ps
module raf_checker (
  input wire        core_clk,
  input wire        reset,
  input wire [15:0] reg_addr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        frame_valid,
  input wire [47:0] frame_da,
  input wire        match_valid,
  input wire        match_accept,
  input wire        exact_hit,
  input wire        mc_hit,
  input wire [3:0]  match_entry
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Read of any high word, primary or shared
  wire hi_rd = reg_rd && reg_addr >= 16'h5404 && reg_addr <= 16'h545c && reg_addr[2];
  // Shared high words only
  wire sh_rd = hi_rd && reg_addr != 16'h5404;
  frame_answer_a: assert property (frame_valid |=> match_valid)
    else $error("no match_valid after frame");
  answer_pulse_a: assert property (!frame_valid |=> !match_valid)
    else $error("match_valid without frame");
  miss_entry_a: assert property (match_valid && !exact_hit |-> match_entry == 4'hf)
    else $error("entry reported on miss");
  hit_entry_a: assert property (match_valid && exact_hit |-> match_entry <= 4'hb)
    else $error("hit entry out of range");
  mc_group_a: assert property (match_valid && mc_hit |-> $past(frame_da[0]))
    else $error("multicast hit on unicast frame");
  accept_sum_a: assert property (match_valid |-> match_accept == (exact_hit || mc_hit))
    else $error("accept differs from hits");
  resv_zero_a: assert property (hi_rd |=> reg_rdata[30:19] == 12'h000)
    else $error("reserved high bits not zero");
  sel_fixed_a: assert property (sh_rd |=> reg_rdata[17:16] == 2'b00)
    else $error("shared select not 00");
  unmapped_zero_a: assert property (reg_rd && reg_addr == 16'h6000 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  reset_out_a: assert property ($fell(reset) |-> match_entry == 4'hf && !match_valid)
    else $error("outputs not idle after reset");
endmodule // raf_checker

bind raf_rx_address_filter raf_checker u_raf_checker (.core_clk, .reset, .reg_addr, .reg_rd,
  .reg_rdata, .frame_valid, .frame_da, .match_valid, .match_accept, .exact_hit, .mc_hit,
  .match_entry);

//--- testbench/raf_frame_src.sv
// Purpose: Receive frame path model facing the filter
// Assumes: Bench pulses send one cycle before the frame
// Notes:   Address lines churn between frames so stale values never match
`timescale 1ns/1ps
module raf_frame_src (
  input  wire        core_clk,
  input  wire        send,
  input  wire [47:0] da_in,
  input  wire [47:0] sa_in,
  output reg         frame_valid,
  output reg  [47:0] frame_da,
  output reg  [47:0] frame_sa
);
  initial begin
    frame_valid = 1'b0;
    frame_da = 48'h0;
    frame_sa = 48'h0;
  end
  // One-cycle frame, byte 1 bit 0 in frame_da[0]; inverted lines otherwise
  always @(posedge core_clk) begin
    frame_valid <= send;
    frame_da <= send ? da_in : ~frame_da;
    frame_sa <= send ? sa_in : ~frame_sa;
  end
endmodule // raf_frame_src

//--- testbench/raf_rx_address_filter_test.sv
// Purpose: Register and match scenarios for the receive address filter
// Assumes: Store words give station 5544_33221100
// Notes:   Host uses whole 32-bit words only
`timescale 1ns/1ps
module raf_rx_address_filter_test;
  reg core_clk, reset, sw_reset, pci_reset, nvm_load, nvm_present, reg_wr, reg_rd, me_wr, send;
  reg [15:0] reg_addr, me_addr;
  reg [31:0] reg_wdata, me_wdata;
  reg [10:0] firmware_write_lock;
  reg [47:0] da, sa;
  reg [9:0] idx;
  wire [31:0] reg_rdata;
  wire frame_valid, match_valid, match_accept, exact_hit, mc_hit, pause_da_hit, pool_output_index;
  wire [47:0] frame_da, frame_sa;
  wire [3:0] match_entry;
  integer mismatches, checked, i;
  raf_rx_address_filter u_raf_rx_address_filter (.core_clk, .reset, .sw_reset, .pci_reset,
    .nvm_load, .nvm_present, .nvm_word0(16'h1100), .nvm_word1(16'h3322), .nvm_word2(16'h5544),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .firmware_write_lock, .me_addr,
    .me_wdata, .me_wr, .frame_valid, .frame_da, .frame_sa, .match_valid, .match_accept,
    .exact_hit, .mc_hit, .pause_da_hit, .pool_output_index, .match_entry);
  raf_frame_src u_raf_frame_src (.core_clk, .send, .da_in(da), .sa_in(sa), .frame_valid,
    .frame_da, .frame_sa);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task summarize;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Host or management write, one cycle strobe
  task wr(input me, input [15:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      if (me) begin
        me_wr <= 1'b1;
        me_addr <= a;
        me_wdata <= d;
      end else begin
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
      end
      @(posedge core_clk);
      me_wr <= 1'b0;
      reg_wr <= 1'b0;
    end
  endtask
  // Read; data stands from the cycle after the strobe until the next read
  task rd(input [15:0] a, input [31:0] exp, input string nm);
    begin
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(nm, exp, reg_rdata);
    end
  endtask
  // Frame check; flags are exact, multicast, pause, output index
  task frm(input [47:0] d, input [47:0] s, input [3:0] ent, input [3:0] flg);
    integer n;
    begin
      @(posedge core_clk);
      send <= 1'b1;
      da <= d;
      sa <= s;
      @(posedge core_clk);
      send <= 1'b0;
      n = 0;
      @(posedge core_clk);
      #1;
      while (match_valid !== 1'b1 && n < 4) begin
        @(posedge core_clk);
        #1 n = n + 1;
      end
      if (n == 4) begin
        mismatches = mismatches + 1;
        summarize;
      end
      chk("match_entry", ent, match_entry);
      chk("flags", flg, {exact_hit, mc_hit, pause_da_hit, pool_output_index});
      chk("match_accept", {31'h0, flg[3] | flg[2]}, {31'h0, match_accept});
    end
  endtask
  task pulse(input integer k);
    begin
      @(posedge core_clk);
      sw_reset <= (k == 0);
      pci_reset <= (k == 1);
      nvm_load <= (k == 2);
      @(posedge core_clk);
      sw_reset <= 1'b0;
      pci_reset <= 1'b0;
      nvm_load <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask
  initial begin
    mismatches = 0;
    checked = 0;
    {reset, nvm_present} = 2'b11;
    {sw_reset, pci_reset, nvm_load, reg_wr, reg_rd, me_wr, send} = 7'h00;
    {reg_addr, me_addr, reg_wdata, me_wdata} = 96'h0;
    {firmware_write_lock, da, sa, idx} = 117'h0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(16'h5400, 32'h3322_1100, "st_lo");
    rd(16'h5404, 32'h8000_5544, "st_hi");
    rd(16'h540c, 32'h0, "sh_hi0");
    rd(16'h6000, 32'h0, "unmapped");
    wr(0, 16'h5404, 32'hfff4_5544);
    rd(16'h5404, 32'h8004_5544, "st_hi_w");
    frm(48'h5544_3322_1100, 48'h0, 4'h0, 4'hb);
    wr(0, 16'h5404, 32'h0000_5544);
    frm(48'h5544_3322_1100, 48'h0, 4'hf, 4'h0);
    wr(0, 16'h5404, 32'h8001_5544);
    frm(48'h2, 48'h5544_3322_1100, 4'h0, 4'h8);
    for (i = 0; i < 11; i = i + 1) begin
      wr(0, 16'h5408 + 8 * i, 32'h0a00_0000 + 2 * i);
      wr(0, 16'h540c + 8 * i, 32'h8003_0066);
      rd(16'h540c + 8 * i, 32'h8000_0066, "sh_hi");
      frm({16'h0066, 32'h0a00_0000 + 2 * i}, 48'h0, i + 1, 4'h8);
    end
    @(posedge core_clk) firmware_write_lock <= 11'h008;
    wr(0, 16'h5420, 32'h1234_5678);
    rd(16'h5420, 32'h0a00_0006, "lock_lo");
    rd(16'h5104, 32'h0001_0008, "status");
    wr(1, 16'h5424, 32'h0004_0066);
    rd(16'h5424, 32'h0004_0066, "me_hi");
    wr(1, 16'h542c, 32'h0);
    rd(16'h542c, 32'h8000_0066, "me_unlocked");
    for (i = 0; i < 4; i = i + 1) begin
      wr(0, 16'h5100, i);
      rd(16'h5100, i, "mc_offset");
      idx = 48'h5a3c_0000_0001 >> (i == 3 ? 34 : 38 - i);
      wr(0, 16'h5200 + 4 * idx[9:5], 32'h1 << idx[4:0]);
      frm(48'h5a3c_0000_0001, 48'h0, 4'hf, 4'h4);
      wr(0, 16'h5200 + 4 * idx[9:5], 32'h0);
    end
    wr(0, 16'h5404, 32'h8000_5544);
    @(posedge core_clk) nvm_present <= 1'b0;
    pulse(0);
    rd(16'h5404, 32'h0000_5544, "sw_clear");
    @(posedge core_clk) nvm_present <= 1'b1;
    pulse(2);
    rd(16'h5404, 32'h8000_5544, "load_set");
    wr(0, 16'h5404, 32'h0000_5544);
    pulse(1);
    rd(16'h5404, 32'h8000_5544, "pci_set");
    summarize;
  end
endmodule // raf_rx_address_filter_test
